// >>> src/ecsr_pkg.sv
package ecsr_pkg;

   // Word-address layout of the control and status map.
   localparam int unsigned ADDR_W     = 16;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned MAP_ADDR_W = 12;

   // Per-range header words, at local offsets within each 0x100-word range.
   localparam logic [7:0] HDR_REVID   = 8'h00;
   localparam logic [7:0] HDR_SCRATCH = 8'h01;
   localparam logic [7:0] HDR_NAME0   = 8'h02;
   localparam logic [7:0] HDR_NAME1   = 8'h03;
   localparam logic [7:0] HDR_NAME2   = 8'h04;
   localparam logic [3:0] HDR_RNG_LO  = 4'h3;
   localparam logic [3:0] HDR_RNG_HI  = 4'hb;
   localparam int unsigned HDR_COUNT  = 9;

   // Range indices (address bits [11:8]).
   localparam logic [3:0] RNG_PHY    = 4'h3;
   localparam logic [3:0] RNG_TXMAC  = 4'h4;
   localparam logic [3:0] RNG_RXMAC  = 4'h5;
   localparam logic [3:0] RNG_TXFC   = 4'h6;
   localparam logic [3:0] RNG_RXFC   = 4'h7;
   localparam logic [3:0] RNG_TXSTAT = 4'h8;
   localparam logic [3:0] RNG_RXSTAT = 4'h9;
   localparam logic [3:0] RNG_TXPTP  = 4'ha;
   localparam logic [3:0] RNG_RXPTP  = 4'hb;

   // Group spans forwarded to the sub-blocks, the KR remap offset, and the reserved span that is not forwarded.
   localparam logic [11:0] KR_LO      = 12'h0b0;
   localparam logic [11:0] KR_HI      = 12'h0bd;
   localparam logic [11:0] KR_FEC_LO  = 12'h0bc;
   localparam logic [11:0] AN_LO      = 12'h0c0;
   localparam logic [11:0] AN_HI      = 12'h0cc;
   localparam logic [11:0] LT_LO      = 12'h0d0;
   localparam logic [11:0] LT_HI      = 12'h0eb;
   localparam logic [11:0] KR_REMAP   = 12'h400;
   localparam logic [11:0] RSV_LO     = 12'h100;
   localparam logic [11:0] RSV_HI     = 12'h2ff;
   localparam logic [11:0] PHY_LO     = 12'h310;
   localparam logic [11:0] PHY_HI     = 12'h344;
   localparam logic [11:0] TXFC_LO    = 12'h605;
   localparam logic [11:0] TXFC_HI    = 12'h60a;
   localparam logic [11:0] RXFC_LO    = 12'h700;
   localparam logic [11:0] RXFC_HI    = 12'h703;
   localparam logic [11:0] TXST_LO    = 12'h800;
   localparam logic [11:0] TXST_HI    = 12'h837;
   localparam logic [11:0] TXST2_LO   = 12'h860;
   localparam logic [11:0] TXST2_HI   = 12'h861;
   localparam logic [11:0] RXST_LO    = 12'h900;
   localparam logic [11:0] RXST_HI    = 12'h937;
   localparam logic [11:0] RXST2_LO   = 12'h960;
   localparam logic [11:0] RXST2_HI   = 12'h961;
   localparam logic [11:0] TXPTP_LO   = 12'ha00;
   localparam logic [11:0] TXPTP_HI   = 12'ha0c;
   localparam logic [11:0] RXPTP_LO   = 12'hb00;
   localparam logic [11:0] RXPTP_HI   = 12'hb06;

   // Registers held inside the decoder.
   localparam logic [11:0] LINK_FAULT_CONFIG_ADDR = 12'h405;
   localparam logic [11:0] GAP_COLUMN_REMOVAL_ADDR = 12'h406;
   localparam logic [11:0] TX_MAX_FRAME_ADDR      = 12'h407;
   localparam logic [11:0] RX_MAX_FRAME_ADDR      = 12'h506;
   localparam logic [11:0] RX_FCS_FORWARD_ADDR    = 12'h507;
   localparam logic [11:0] LINK_FAULT_STATUS_ADDR = 12'h508;
   localparam logic [11:0] RX_LEN_CHECK_ADDR      = 12'h50a;
   localparam logic [11:0] TX_STATS_CONFIG_ADDR   = 12'h845;
   localparam logic [11:0] TX_STATS_STATUS_ADDR   = 12'h846;
   localparam logic [11:0] RX_STATS_CONFIG_ADDR   = 12'h945;
   localparam logic [11:0] RX_STATS_STATUS_ADDR   = 12'h946;

   // Reset values and fixed read values.
   localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
   localparam logic [31:0] MAX_FRAME_RESET  = 32'h0000_05ee;
   localparam logic [31:0] RESERVED_READ    = 32'h0000_0000;
   localparam int unsigned LEN_CHECK_BIT    = 0;

   // Name words: two fixed words, then a tag carrying the range index.
   localparam logic [31:0] NAME_WORD0  = 32'h6373_725f;
   localparam logic [31:0] NAME_WORD1  = 32'h726e_675f;
   localparam logic [23:0] NAME_PREFIX = 24'h7267_5f;

   // Downstream group codes.
   localparam logic [3:0] GRP_NONE   = 4'h0;
   localparam logic [3:0] GRP_KR     = 4'h1;
   localparam logic [3:0] GRP_AN     = 4'h2;
   localparam logic [3:0] GRP_LT     = 4'h3;
   localparam logic [3:0] GRP_PHY    = 4'h4;
   localparam logic [3:0] GRP_TXFC   = 4'h5;
   localparam logic [3:0] GRP_RXFC   = 4'h6;
   localparam logic [3:0] GRP_TXSTAT = 4'h7;
   localparam logic [3:0] GRP_RXSTAT = 4'h8;
   localparam logic [3:0] GRP_TXPTP  = 4'h9;
   localparam logic [3:0] GRP_RXPTP  = 4'ha;

   // Flow control build modes.
   localparam logic [1:0] FC_NONE     = 2'h0;
   localparam logic [1:0] FC_STANDARD = 2'h1;
   localparam logic [1:0] FC_PRIORITY = 2'h2;

endpackage : ecsr_pkg

// >>> src/ecsr_decoder.sv
`timescale 1ns/1ns
// Contract
// - All registers 32-bit, word addressed only.
// - Ranges 3-B have revision, scratch, name words; forwarded groups win where they overlap.
// - KR/FEC words need KR; FEC also FEC.
// - Auto-negotiation words need KR and AN.
// - Link-training words need KR and LT.
// - KR PHY words forwarded at offset plus 0x400.
// - PHY words always decoded.
// - Link-fault config needs link-fault option.
// - Gap column removal needs average gap option.
// - TX max length decides TX oversize count.
// - RX max length decides RX oversize count.
// - RX FCS forwarding word always present.
// - Link-fault status reads zero without option.
// - Length check bit gates RX length error.
// - TX pause words need flow control mode.
// - RX pause words need flow control mode.
// - TX statistics words need TX statistics.
// - RX statistics words need RX statistics.
// - TX timestamp words need PTP.
// - RX timestamp words need PTP.
// - Writes to read-only fields do nothing.
// - Reserved words read constant, ignore writes.
// - Words 0x100-0x2FF are reserved.
module ecsr_decoder #(
   parameter bit          ENABLE_KR         = 1'b1,
   parameter bit          ENABLE_FEC        = 1'b1,
   parameter bit          ENABLE_AN         = 1'b1,
   parameter bit          ENABLE_LT         = 1'b1,
   parameter bit          ENABLE_LINK_FAULT = 1'b1,
   parameter bit          ENABLE_AVG_GAP    = 1'b1,
   parameter logic [1:0]  FLOW_CONTROL_MODE = ecsr_pkg::FC_STANDARD,
   parameter bit          ENABLE_TX_STATS   = 1'b1,
   parameter bit          ENABLE_RX_STATS   = 1'b1,
   parameter bit          ENABLE_PTP        = 1'b1,
   // Arbitrary neutral revision value.
   parameter logic [31:0] REVISION_ID       = 32'h0000_0001
) (
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   // Control and status port from the host.
   input  wire logic [15:0] csr_addr_i,
   input  wire logic        csr_read_i,
   input  wire logic        csr_write_i,
   input  wire logic [31:0] csr_writedata_i,
   output logic [31:0]      csr_readdata_o,
   output logic             csr_readdata_valid_o,
   // Forwarded access to the register sub-blocks.
   output logic [3:0]       sub_group_o,
   output logic [11:0]      sub_addr_o,
   output logic             sub_read_o,
   output logic             sub_write_o,
   output logic [31:0]      sub_writedata_o,
   input  wire logic [31:0] sub_readdata_i,
   // Configuration words held here.
   output logic [31:0]      link_fault_config_o,
   output logic [31:0]      gap_column_removal_o,
   output logic [31:0]      tx_max_frame_length_o,
   output logic [31:0]      rx_max_frame_length_o,
   output logic [31:0]      rx_fcs_forward_config_o,
   output logic [31:0]      tx_stats_config_o,
   output logic [31:0]      rx_stats_config_o,
   // Status words read through the map.
   input  wire logic [31:0] link_fault_status_i,
   input  wire logic [31:0] tx_stats_status_i,
   input  wire logic [31:0] rx_stats_status_i,
   // Frame events from the datapath.
   input  wire logic        tx_frame_done_i,
   input  wire logic [31:0] tx_frame_bytes_i,
   input  wire logic        rx_frame_done_i,
   input  wire logic [31:0] rx_frame_bytes_i,
   input  wire logic        rx_len_mismatch_i,
   // Results toward the statistics and error logic.
   output logic             tx_oversize_counter_inc_o,
   output logic             rx_oversize_counter_inc_o,
   output logic             rx_length_error_o
);

   // Inclusive span test used by every group decode.
   function automatic logic in_span(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // Whether a 0x100-word range is built, so its header words answer.
   function automatic logic range_present(input logic [3:0] r);
      logic p;
      p = 1'b0;
      case (r)
         ecsr_pkg::RNG_PHY,
         ecsr_pkg::RNG_TXMAC,
         ecsr_pkg::RNG_RXMAC:  p = 1'b1;
         ecsr_pkg::RNG_TXFC,
         ecsr_pkg::RNG_RXFC:   p = (FLOW_CONTROL_MODE != ecsr_pkg::FC_NONE);
         ecsr_pkg::RNG_TXSTAT: p = ENABLE_TX_STATS;
         ecsr_pkg::RNG_RXSTAT: p = ENABLE_RX_STATS;
         ecsr_pkg::RNG_TXPTP,
         ecsr_pkg::RNG_RXPTP:  p = ENABLE_PTP;
         default:              p = 1'b0;
      endcase
      return p;
   endfunction

   // Address split; only the low 12 bits carry this map.
   wire logic [11:0] map_addr;
   wire logic        in_map;
   wire logic [3:0]  rng;
   wire logic [7:0]  local_off;
   assign map_addr  = csr_addr_i[11:0];
   assign in_map    = (csr_addr_i[15:12] == 4'h0);
   assign rng       = map_addr[11:8];
   assign local_off = map_addr[7:0];

   // Build-option gating for the forwarded groups.
   wire logic fc_built;
   wire logic fec_word;
   wire logic hit_kr;
   wire logic hit_an;
   wire logic hit_lt;
   wire logic hit_phy;
   wire logic hit_txfc;
   wire logic hit_rxfc;
   wire logic hit_txst;
   wire logic hit_rxst;
   wire logic hit_txptp;
   wire logic hit_rxptp;
   assign fc_built  = (FLOW_CONTROL_MODE == ecsr_pkg::FC_STANDARD) ||
                      (FLOW_CONTROL_MODE == ecsr_pkg::FC_PRIORITY);
   assign fec_word  = (map_addr >= ecsr_pkg::KR_FEC_LO);
   assign hit_kr    = in_map && ENABLE_KR && in_span(map_addr, ecsr_pkg::KR_LO, ecsr_pkg::KR_HI)
                      && (!fec_word || ENABLE_FEC);
   assign hit_an    = in_map && ENABLE_KR && ENABLE_AN
                      && in_span(map_addr, ecsr_pkg::AN_LO, ecsr_pkg::AN_HI);
   assign hit_lt    = in_map && ENABLE_KR && ENABLE_LT
                      && in_span(map_addr, ecsr_pkg::LT_LO, ecsr_pkg::LT_HI);
   assign hit_phy   = in_map && in_span(map_addr, ecsr_pkg::PHY_LO, ecsr_pkg::PHY_HI);
   assign hit_txfc  = in_map && fc_built && in_span(map_addr, ecsr_pkg::TXFC_LO, ecsr_pkg::TXFC_HI);
   assign hit_rxfc  = in_map && fc_built && in_span(map_addr, ecsr_pkg::RXFC_LO, ecsr_pkg::RXFC_HI);
   assign hit_txst  = in_map && ENABLE_TX_STATS
                      && (in_span(map_addr, ecsr_pkg::TXST_LO, ecsr_pkg::TXST_HI)
                      ||  in_span(map_addr, ecsr_pkg::TXST2_LO, ecsr_pkg::TXST2_HI));
   assign hit_rxst  = in_map && ENABLE_RX_STATS
                      && (in_span(map_addr, ecsr_pkg::RXST_LO, ecsr_pkg::RXST_HI)
                      ||  in_span(map_addr, ecsr_pkg::RXST2_LO, ecsr_pkg::RXST2_HI));
   assign hit_txptp = in_map && ENABLE_PTP && in_span(map_addr, ecsr_pkg::TXPTP_LO, ecsr_pkg::TXPTP_HI);
   assign hit_rxptp = in_map && ENABLE_PTP && in_span(map_addr, ecsr_pkg::RXPTP_LO, ecsr_pkg::RXPTP_HI);

   // Group code for the forwarded access; at most one hit is true at a time.
   wire logic [3:0] grp;
   assign grp = hit_kr    ? ecsr_pkg::GRP_KR     :
                hit_an    ? ecsr_pkg::GRP_AN     :
                hit_lt    ? ecsr_pkg::GRP_LT     :
                hit_phy   ? ecsr_pkg::GRP_PHY    :
                hit_txfc  ? ecsr_pkg::GRP_TXFC   :
                hit_rxfc  ? ecsr_pkg::GRP_RXFC   :
                hit_txst  ? ecsr_pkg::GRP_TXSTAT :
                hit_rxst  ? ecsr_pkg::GRP_RXSTAT :
                hit_txptp ? ecsr_pkg::GRP_TXPTP  :
                hit_rxptp ? ecsr_pkg::GRP_RXPTP  : ecsr_pkg::GRP_NONE;

   wire logic hit_sub;
   wire logic kr_family;
   assign hit_sub   = (grp != ecsr_pkg::GRP_NONE);
   assign kr_family = hit_kr || hit_an || hit_lt;

   // The embedded KR PHY sees its own internal offsets, not the host's.
   assign sub_group_o     = grp;
   assign sub_addr_o      = kr_family ? (map_addr + ecsr_pkg::KR_REMAP) : map_addr;
   assign sub_read_o      = csr_read_i && hit_sub;
   assign sub_write_o     = csr_write_i && hit_sub;
   assign sub_writedata_o = csr_writedata_i;

   // Words held here; a forwarded group wins over the header at the same word.
   wire logic hit_lf_cfg;
   wire logic hit_gap;
   wire logic hit_txmax;
   wire logic hit_rxmax;
   wire logic hit_fcs;
   wire logic hit_lf_stat;
   wire logic hit_lencheck;
   wire logic hit_txst_cfg;
   wire logic hit_txst_stat;
   wire logic hit_rxst_cfg;
   wire logic hit_rxst_stat;
   wire logic hit_hdr;
   assign hit_lf_cfg    = in_map && ENABLE_LINK_FAULT && (map_addr == ecsr_pkg::LINK_FAULT_CONFIG_ADDR);
   assign hit_gap       = in_map && ENABLE_AVG_GAP && (map_addr == ecsr_pkg::GAP_COLUMN_REMOVAL_ADDR);
   assign hit_txmax     = in_map && (map_addr == ecsr_pkg::TX_MAX_FRAME_ADDR);
   assign hit_rxmax     = in_map && (map_addr == ecsr_pkg::RX_MAX_FRAME_ADDR);
   assign hit_fcs       = in_map && (map_addr == ecsr_pkg::RX_FCS_FORWARD_ADDR);
   assign hit_lf_stat   = in_map && (map_addr == ecsr_pkg::LINK_FAULT_STATUS_ADDR);
   assign hit_lencheck  = in_map && (map_addr == ecsr_pkg::RX_LEN_CHECK_ADDR);
   assign hit_txst_cfg  = in_map && ENABLE_TX_STATS && (map_addr == ecsr_pkg::TX_STATS_CONFIG_ADDR);
   assign hit_txst_stat = in_map && ENABLE_TX_STATS && (map_addr == ecsr_pkg::TX_STATS_STATUS_ADDR);
   assign hit_rxst_cfg  = in_map && ENABLE_RX_STATS && (map_addr == ecsr_pkg::RX_STATS_CONFIG_ADDR);
   assign hit_rxst_stat = in_map && ENABLE_RX_STATS && (map_addr == ecsr_pkg::RX_STATS_STATUS_ADDR);
   assign hit_hdr       = in_map && !hit_sub && (rng >= ecsr_pkg::HDR_RNG_LO) && (rng <= ecsr_pkg::HDR_RNG_HI)
                          && (local_off <= ecsr_pkg::HDR_NAME2) && range_present(rng);

   // Scratch word index within the header array.
   wire logic [3:0] hdr_idx;
   assign hdr_idx = rng - ecsr_pkg::HDR_RNG_LO;

   // Full-word write strobes; there are no byte lanes to merge.
   wire logic wr_en;
   wire logic wr_scratch;
   assign wr_en      = csr_write_i && in_map;
   assign wr_scratch = wr_en && hit_hdr && (local_off == ecsr_pkg::HDR_SCRATCH);

   // Configuration and scratch storage.
   logic [31:0] scratch_reg [0:ecsr_pkg::HDR_COUNT-1];
   logic [31:0] link_fault_config_reg;
   logic [31:0] gap_column_removal_reg;
   logic [31:0] tx_max_frame_length_reg;
   logic [31:0] rx_max_frame_length_reg;
   logic [31:0] rx_fcs_forward_config_reg;
   logic [31:0] rx_length_check_enable_reg;
   logic [31:0] tx_stats_config_reg;
   logic [31:0] rx_stats_config_reg;

   // Header read value.
   wire logic [31:0] hdr_word;
   assign hdr_word = (local_off == ecsr_pkg::HDR_REVID)   ? REVISION_ID :
                     (local_off == ecsr_pkg::HDR_SCRATCH) ? scratch_reg[hdr_idx] :
                     (local_off == ecsr_pkg::HDR_NAME0)   ? ecsr_pkg::NAME_WORD0 :
                     (local_off == ecsr_pkg::HDR_NAME1)   ? ecsr_pkg::NAME_WORD1 :
                                                            {ecsr_pkg::NAME_PREFIX, 4'h0, rng};

   // Read-only words return the status inputs; without link-fault logic the status is zero.
   wire logic [31:0] lf_status_word;
   assign lf_status_word = ENABLE_LINK_FAULT ? link_fault_status_i : ecsr_pkg::ZERO_WORD;

   // Read selection; anything not decoded returns one fixed constant.
   wire logic [31:0] rd_mux;
   assign rd_mux = hit_sub       ? sub_readdata_i             :
                   hit_lf_cfg    ? link_fault_config_reg      :
                   hit_gap       ? gap_column_removal_reg     :
                   hit_txmax     ? tx_max_frame_length_reg    :
                   hit_rxmax     ? rx_max_frame_length_reg    :
                   hit_fcs       ? rx_fcs_forward_config_reg  :
                   hit_lf_stat   ? lf_status_word             :
                   hit_lencheck  ? rx_length_check_enable_reg :
                   hit_txst_cfg  ? tx_stats_config_reg        :
                   hit_txst_stat ? tx_stats_status_i          :
                   hit_rxst_cfg  ? rx_stats_config_reg        :
                   hit_rxst_stat ? rx_stats_status_i          :
                   hit_hdr       ? hdr_word                   :
                                   ecsr_pkg::RESERVED_READ;

   // Scratch words; reset to zero so a first read is deterministic.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < ecsr_pkg::HDR_COUNT; i++) begin
            scratch_reg[i] <= ecsr_pkg::ZERO_WORD;
         end
      end else if (wr_scratch) begin
         scratch_reg[hdr_idx] <= csr_writedata_i;
      end
   end

   // Writable configuration; writes elsewhere, reserved or read-only, fall through untouched.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         link_fault_config_reg      <= ecsr_pkg::ZERO_WORD;
         gap_column_removal_reg     <= ecsr_pkg::ZERO_WORD;
         tx_max_frame_length_reg    <= ecsr_pkg::MAX_FRAME_RESET;
         rx_max_frame_length_reg    <= ecsr_pkg::MAX_FRAME_RESET;
         rx_fcs_forward_config_reg  <= ecsr_pkg::ZERO_WORD;
         rx_length_check_enable_reg <= ecsr_pkg::ZERO_WORD;
         tx_stats_config_reg        <= ecsr_pkg::ZERO_WORD;
         rx_stats_config_reg        <= ecsr_pkg::ZERO_WORD;
      end else if (wr_en) begin
         if (hit_lf_cfg)   link_fault_config_reg      <= csr_writedata_i;
         if (hit_gap)      gap_column_removal_reg     <= csr_writedata_i;
         if (hit_txmax)    tx_max_frame_length_reg    <= csr_writedata_i;
         if (hit_rxmax)    rx_max_frame_length_reg    <= csr_writedata_i;
         if (hit_fcs)      rx_fcs_forward_config_reg  <= csr_writedata_i;
         if (hit_lencheck) rx_length_check_enable_reg <= csr_writedata_i;
         if (hit_txst_cfg) tx_stats_config_reg        <= csr_writedata_i;
         if (hit_rxst_cfg) rx_stats_config_reg        <= csr_writedata_i;
      end
   end

   // Read answer one cycle after the request, captured so the host sees a stable word.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         csr_readdata_o       <= ecsr_pkg::ZERO_WORD;
         csr_readdata_valid_o <= 1'b0;
      end else begin
         csr_readdata_valid_o <= csr_read_i;
         if (csr_read_i) begin
            csr_readdata_o <= rd_mux;
         end
      end
   end

   // Frame checks against the limits; only frames longer than the limit count.
   wire logic tx_over;
   wire logic rx_over;
   wire logic rx_len_err;
   assign tx_over    = tx_frame_done_i && (tx_frame_bytes_i > tx_max_frame_length_reg);
   assign rx_over    = rx_frame_done_i && (rx_frame_bytes_i > rx_max_frame_length_reg);
   assign rx_len_err = rx_frame_done_i && rx_len_mismatch_i
                       && rx_length_check_enable_reg[ecsr_pkg::LEN_CHECK_BIT];

   // Registered event pulses, one cycle after the frame end.
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_oversize_counter_inc_o <= 1'b0;
         rx_oversize_counter_inc_o <= 1'b0;
         rx_length_error_o         <= 1'b0;
      end else begin
         tx_oversize_counter_inc_o <= tx_over;
         rx_oversize_counter_inc_o <= rx_over;
         rx_length_error_o         <= rx_len_err;
      end
   end

   // Configuration words drive the datapath directly from their registers.
   assign link_fault_config_o     = link_fault_config_reg;
   assign gap_column_removal_o    = gap_column_removal_reg;
   assign tx_max_frame_length_o   = tx_max_frame_length_reg;
   assign rx_max_frame_length_o   = rx_max_frame_length_reg;
   assign rx_fcs_forward_config_o = rx_fcs_forward_config_reg;
   assign tx_stats_config_o       = tx_stats_config_reg;
   assign rx_stats_config_o       = rx_stats_config_reg;

endmodule // ecsr_decoder

// >>> test/ecsr_checker.sv
`timescale 1ns/1ns
// Ties each answer to its cause.
module ecsr_checker (
   input wire logic        mclk_i, resetn_i, csr_read_i, csr_write_i, csr_readdata_valid_o, sub_read_o, sub_write_o,
   input wire logic        tx_frame_done_i, rx_frame_done_i, rx_len_mismatch_i, tx_oversize_counter_inc_o,
   input wire logic        rx_oversize_counter_inc_o, rx_length_error_o,
   input wire logic [15:0] csr_addr_i,
   input wire logic [11:0] sub_addr_o,
   input wire logic [3:0]  sub_group_o,
   input wire logic [31:0] csr_writedata_i, csr_readdata_o, tx_frame_bytes_i, rx_frame_bytes_i,
   input wire logic [31:0] tx_max_frame_length_o, rx_max_frame_length_o, sub_writedata_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   // One answer a cycle after each read.
   a_read_answer: assert property (csr_readdata_valid_o == $past(csr_read_i))
      else $error("read answer out of step");
   a_kr_remap: assert property (sub_read_o && sub_group_o == ecsr_pkg::GRP_KR |->
      sub_addr_o == csr_addr_i[11:0] + 12'h400) else $error("kr address not moved up");
   a_phy_always: assert property (csr_read_i && csr_addr_i inside {[16'h0310:16'h0344]} |->
      sub_read_o && sub_group_o == ecsr_pkg::GRP_PHY) else $error("phy word not forwarded");
   a_reserved_zero: assert property (csr_read_i && csr_addr_i inside {[16'h0100:16'h02ff]} |->
      !sub_read_o ##1 csr_readdata_o == ecsr_pkg::RESERVED_READ) else $error("reserved word not constant");
   a_tx_limit_write: assert property (csr_write_i && csr_addr_i == 16'h0407 |=>
      tx_max_frame_length_o == $past(csr_writedata_i)) else $error("tx limit not written");
   // Strictly greater than the limit.
   a_tx_oversize: assert property (tx_oversize_counter_inc_o ==
      $past(tx_frame_done_i && tx_frame_bytes_i > tx_max_frame_length_o)) else $error("tx oversize wrong");
   a_rx_oversize: assert property (rx_oversize_counter_inc_o ==
      $past(rx_frame_done_i && rx_frame_bytes_i > rx_max_frame_length_o)) else $error("rx oversize wrong");
   a_length_error: assert property (rx_length_error_o |->
      $past(rx_frame_done_i && rx_len_mismatch_i)) else $error("length error without cause");
   a_phy_write: assert property (csr_write_i && csr_addr_i inside {[16'h0310:16'h0344]} |->
      sub_write_o && sub_writedata_o == csr_writedata_i) else $error("phy write lost");
   c_kr_read: cover property (sub_read_o && sub_group_o == ecsr_pkg::GRP_KR);
   c_tx_over: cover property (tx_oversize_counter_inc_o);
   c_len_err: cover property (rx_length_error_o);
endmodule // ecsr_checker
bind ecsr_decoder ecsr_checker u_ecsr_checker (.*);

// >>> test/ecsr_sub_model.sv
`timescale 1ns/1ns
// Register sub-blocks: answer at once with group and address.
module ecsr_sub_model (
   input  wire logic        mclk_i,
   input  wire logic        sub_read_i,
   input  wire logic [3:0]  sub_group_i,
   input  wire logic [11:0] sub_addr_i,
   output logic [31:0]      sub_readdata_o
);
   logic [31:0] junk_reg = 32'h5a5a_0f0f;
   // A moving idle pattern exposes stale samples.
   always @(posedge mclk_i) junk_reg <= ~junk_reg + 32'h1;
   assign sub_readdata_o = sub_read_i ? {sub_group_i, 16'h0, sub_addr_i} : junk_reg;
endmodule // ecsr_sub_model

// >>> test/test_ecsr_decoder.sv
`timescale 1ns/1ns
module test_ecsr_decoder;
   localparam logic [31:0] REV = 32'h0000_0007; // Arbitrary revision value.
   logic        mclk_i = 1'b0, resetn_i = 1'b0, csr_read_i = 1'b0, csr_write_i = 1'b0, sub_read_o, sub_write_o;
   logic        tx_frame_done_i = 1'b0, rx_frame_done_i = 1'b0, rx_len_mismatch_i = 1'b0, csr_readdata_valid_o;
   logic        tx_oversize_counter_inc_o, rx_oversize_counter_inc_o, rx_length_error_o;
   logic [15:0] csr_addr_i = 16'h0;
   logic [3:0]  sub_group_o;
   logic [11:0] sub_addr_o;
   logic [31:0] csr_writedata_i = 32'h0, tx_frame_bytes_i = 32'h0, rx_frame_bytes_i = 32'h0, csr_readdata_o;
   logic [31:0] sub_writedata_o, sub_readdata_i, tx_max_frame_length_o, rx_max_frame_length_o, link_fault_config_o;
   logic [31:0] gap_column_removal_o, rx_fcs_forward_config_o, tx_stats_config_o, rx_stats_config_o;
   logic [31:0] link_fault_status_i = 32'h3, tx_stats_status_i = 32'h846, rx_stats_status_i = 32'h946;
   int          n_fail = 0, tests_run = 0;
   always #5 mclk_i = ~mclk_i;
   ecsr_decoder #(.REVISION_ID(REV)) u_ecsr_decoder (.*);
   ecsr_sub_model u_ecsr_sub_model (.mclk_i(mclk_i), .sub_read_i(sub_read_o), .sub_group_i(sub_group_o),
      .sub_addr_i(sub_addr_o), .sub_readdata_o(sub_readdata_i));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Requests start at a falling edge, held over one rising edge.
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge mclk_i);
      {csr_write_i, csr_addr_i, csr_writedata_i} = {1'b1, a, d};
      @(negedge mclk_i);
      csr_write_i = 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(negedge mclk_i);
      {csr_read_i, csr_addr_i} = {1'b1, a};
      @(negedge mclk_i);
      csr_read_i = 1'b0;
      check({31'h0, csr_readdata_valid_o}, 32'h1);
      check(csr_readdata_o, exp);
   endtask
   task automatic t_regs();
      logic [15:0] a [7] = '{16'h0405, 16'h0406, 16'h0407, 16'h0506, 16'h0507, 16'h0845, 16'h0945};
      rd(16'h0407, ecsr_pkg::MAX_FRAME_RESET);
      rd(16'h0506, ecsr_pkg::MAX_FRAME_RESET);
      foreach (a[i]) begin
         wr(a[i], {16'hc3a5, a[i]});
         rd(a[i], {16'hc3a5, a[i]});
      end
      check(rx_fcs_forward_config_o, 32'hc3a5_0507);
      check({link_fault_config_o[15:0], gap_column_removal_o[15:0]}, 32'h0405_0406);
      check({tx_stats_config_o[15:0], rx_stats_config_o[15:0]}, 32'h0845_0945);
      wr(16'h0508, 32'h0);
      wr(16'h0846, 32'h0);
      rd(16'h0508, 32'h3);
      rd(16'h0846, 32'h846);
      rd(16'h0946, 32'h946);
   endtask
   task automatic t_headers();
      for (logic [3:0] r = 4'h3; r < 4'h7; r++) begin
         rd({4'h0, r, 8'h00}, REV);
         rd({4'h0, r, 8'h01}, 32'h0);
         wr({4'h0, r, 8'h01}, {28'h5a5a_aaa, r});
         rd({4'h0, r, 8'h01}, {28'h5a5a_aaa, r});
         rd({4'h0, r, 8'h02}, ecsr_pkg::NAME_WORD0);
         rd({4'h0, r, 8'h03}, ecsr_pkg::NAME_WORD1);
         rd({4'h0, r, 8'h04}, {ecsr_pkg::NAME_PREFIX, 4'h0, r});
      end
   endtask
   // First or last word of each forwarded span; both ends for KR and PHY.
   task automatic t_forward();
      logic [15:0] a [14] = '{16'h00b0, 16'h00bd, 16'h00c0, 16'h00eb, 16'h0310, 16'h0344, 16'h0605, 16'h0703,
                              16'h0800, 16'h0861, 16'h0900, 16'h0961, 16'h0a0c, 16'h0b06};
      logic [3:0]  g [14] = '{4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'ha};
      foreach (a[i]) rd(a[i], {g[i], 16'h0, a[i][11:0] + (a[i] < 16'h0100 ? 12'h400 : 12'h0)});
   endtask
   task automatic t_quiet();
      logic [15:0] a [7] = '{16'h00be, 16'h00cd, 16'h00ec, 16'h0100, 16'h02ff, 16'h0345, 16'h1000};
      wr(16'h0200, 32'hffff_ffff);
      wr(16'h0344, 32'h1);
      foreach (a[i]) rd(a[i], ecsr_pkg::RESERVED_READ);
   endtask
   task automatic t_events();
      wr(16'h0407, 32'h5ee);
      wr(16'h0506, 32'h40);
      wr(16'h050a, 32'h1);
      @(negedge mclk_i);
      {tx_frame_done_i, tx_frame_bytes_i, rx_frame_done_i, rx_frame_bytes_i, rx_len_mismatch_i} = {1'b1, 32'h5ee, 1'b1, 32'h41, 1'b1};
      @(negedge mclk_i);
      {tx_frame_bytes_i, rx_frame_bytes_i, rx_len_mismatch_i} = {32'h5ef, 32'h40, 1'b0};
      check({29'h0, tx_oversize_counter_inc_o, rx_oversize_counter_inc_o, rx_length_error_o}, 32'h3);
      @(negedge mclk_i);
      {tx_frame_done_i, rx_frame_done_i} = 2'b00;
      check({29'h0, tx_oversize_counter_inc_o, rx_oversize_counter_inc_o, rx_length_error_o}, 32'h4);
      wr(16'h050a, 32'h0);
      {rx_frame_done_i, rx_len_mismatch_i} = 2'b11;
      @(negedge mclk_i);
      rx_frame_done_i = 1'b0;
      check({31'h0, rx_length_error_o}, 32'h0);
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Hold reset eight cycles, then run each scenario.
   initial begin
      repeat (8) @(negedge mclk_i);
      resetn_i = 1'b1;
      t_regs();
      t_headers();
      t_forward();
      t_quiet();
      t_events();
      give_verdict();
   end
   // A hang counts as a mismatch.
   initial begin
      #200000;
      n_fail++;
      give_verdict();
   end
endmodule // test_ecsr_decoder
